// ==== pkg/ptmc_pkg.sv ====
// Constants for the prescaled timer with match and capture channels.
// Assumes a 32-bit APB register bus and byte addresses as printed.
package ptmc_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned NCH = 4;
  localparam int unsigned PINS_PER_CAP = 3;

  // ==========================================================
  // Register byte addresses
  localparam logic [31:0] ADDR_FLAGS = 32'hE000_4000;
  localparam logic [31:0] ADDR_CTRL = 32'hE000_4004;
  localparam logic [31:0] ADDR_TICK = 32'hE000_4008;
  localparam logic [31:0] ADDR_LIMIT = 32'hE000_400C;
  localparam logic [31:0] ADDR_DIVC = 32'hE000_4010;
  localparam logic [31:0] ADDR_ACTION = 32'hE000_4014;
  localparam logic [31:0] ADDR_CMP0 = 32'hE000_4018;
  localparam logic [31:0] ADDR_EDGE = 32'hE000_4028;
  localparam logic [31:0] ADDR_SNAP0 = 32'hE000_402C;
  localparam logic [31:0] ADDR_PINS = 32'hE000_403C;
  localparam logic [31:0] ADDR_STRIDE = 32'h0000_0004;

  // ==========================================================
  // Field positions
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_CLR_BIT = 1;
  localparam int unsigned ACT_IRQ_BIT = 0;
  localparam int unsigned ACT_RST_BIT = 1;
  localparam int unsigned ACT_STOP_BIT = 2;
  localparam int unsigned ACT_STRIDE = 3;
  localparam int unsigned EDGE_RISE_BIT = 0;
  localparam int unsigned EDGE_FALL_BIT = 1;
  localparam int unsigned EDGE_IRQ_BIT = 2;
  localparam int unsigned EDGE_STRIDE = 3;
  localparam int unsigned PIN_FIELD_LSB = 4;
  localparam int unsigned PIN_FIELD_W = 2;
  localparam int unsigned FLAG_CAP_LSB = 4;

  // ==========================================================
  // Values after reset, plus the all-ones and one-word constants
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [11:0] RST_CFG12 = 12'h000;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
  localparam logic [31:0] ONE_WORD = 32'h0000_0001;

  // ==========================================================
  // Compare pin actions
  typedef enum logic [1:0] {
    PIN_KEEP = 2'h0,
    PIN_LOW = 2'h1,
    PIN_HIGH = 2'h2,
    PIN_TOGGLE = 2'h3
  } ptmc_pin_act_e;

endpackage

// ==== pkg/ptmc_cap_if.sv ====
// Edge events passed from the capture front end to the timer core.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface ptmc_cap_if;
  logic [3:0] rise;
  logic [3:0] fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface

// ==== hdl/ptmc_capture.sv ====
// Capture front end: pin merge, two-stage synchroniser, edge detect.
// Assumes pclk_en freezes state like the rest of the timer.
`timescale 1ns/1ps
module ptmc_capture (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  // Pins, three per channel
  input wire logic [11:0] pins,
  // Edge events
  ptmc_cap_if.src cap
);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] prev;
  } ptmc_capsync_s;

  ptmc_capsync_s st_reg;
  ptmc_capsync_s st_next;
  logic [3:0] pin_or;

  // ==========================================================
  // Merge of routed pins per channel
  genvar ch;
  generate
    for (ch = 0; ch < ptmc_pkg::NCH; ch++) begin : g_or
      assign pin_or[ch] = |pins[ch*ptmc_pkg::PINS_PER_CAP +: ptmc_pkg::PINS_PER_CAP]; // RULE_19
    end
  endgenerate

  // Synchroniser and previous sample
  always_comb begin
    st_next = st_reg;
    if (pclk_en) begin
      st_next.s1 = pin_or;
      st_next.s2 = st_reg.s1; // RULE_20
      st_next.prev = st_reg.s2;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Edges from the second stage against the sample before it
  assign cap.rise = st_reg.s2 & ~st_reg.prev; // RULE_20
  assign cap.fall = ~st_reg.s2 & st_reg.prev;

endmodule

// ==== hdl/ptmc_top.sv ====
// Timer core: prescaler, tick counter, four compare and four capture
// channels, APB register slave.
// Assumes an APB master on pclk and capture pins synchronous to pclk.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps

// Operation
// [RULE_01] Enable bit set: both counters count; clear: both hold.
// [RULE_02] Clear bit set: both counters zeroed each edge until it drops.
// [RULE_03] Tick counter wraps from all ones to zero, no flag.
// [RULE_04] Divider counts each cycle; at limit, tick advances, divider zeroes.
// [RULE_05] Each compare value checked against tick counter all the time.
// [RULE_06] Action bits per channel: flag, clear tick, stop.
// [RULE_07] Stop on match halts both counters and clears enable bit.
// [RULE_08] Clear on match happens at end of the matching prescaled cycle.
// [RULE_09] Match flag sets one cycle after tick reaches compare value.
// [RULE_10] Stop clears enable bit in that same cycle as the flag.
// [RULE_11] Rising edge enable loads snapshot with tick counter.
// [RULE_12] Falling edge enable loads snapshot with tick counter.
// [RULE_13] Both edges enabled is legal and captures on each edge.
// [RULE_14] Capture flag enable sets channel flag on each snapshot load.
// [RULE_15] Flag bit 7 shows a capture event on channel 3.
// [RULE_16] Pin control bits 0 to 3 show compare output states.
// [RULE_17] Match updates compare output by its two-bit field.
// [RULE_18] Writing one clears a flag; writing zero leaves it.
// [RULE_19] Several pins on one capture input are ORed together.
// [RULE_20] Capture inputs synchronised; edges from successive samples.
// [RULE_21] Bus write to tick or divider beats internal update.
module ptmc_top (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic [11:0] snapshot_input,
  output logic [3:0] compare_output
);

  typedef struct packed {
    logic [1:0] counter_ctrl;
    logic [31:0] tick_count;
    logic [31:0] divider_limit;
    logic [31:0] divider_count;
    logic [11:0] match_action_ctrl;
    logic [3:0][31:0] compare_value;
    logic [11:0] snapshot_edge_ctrl;
    logic [3:0][31:0] snapshot_value;
    logic [11:0] compare_pin_ctrl;
    logic [7:0] event_flags;
    logic fresh;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ptmc_state_s;

  ptmc_state_s st_reg;
  ptmc_state_s st_next;
  ptmc_cap_if cap_if ();

  logic wr;
  logic wr_tick;
  logic wr_divc;
  logic wr_ctrl;
  logic wr_pins;
  logic wr_flags;
  logic mapped;
  logic [31:0] rdata;
  logic [3:0] match_now;
  logic [3:0] match_evt;
  logic [3:0] rst_hit;
  logic [3:0] stop_hit;
  logic [3:0] cap_evt;
  logic stop_now;
  logic counting;
  logic step;

  // ==========================================================
  // Capture front end
  ptmc_capture u_capture (
    .pclk (pclk),
    .presetn (presetn),
    .pclk_en (pclk_en),
    .pins (snapshot_input),
    .cap (cap_if.src)
  );

  // ==========================================================
  // Per-channel compare and capture terms
  genvar ch;
  generate
    for (ch = 0; ch < ptmc_pkg::NCH; ch++) begin : g_ch
      // Continuous equality
      assign match_now[ch] = st_reg.tick_count == st_reg.compare_value[ch]; // RULE_05
      // Event only on the cycle after the tick counter took the value
      assign match_evt[ch] = match_now[ch] & st_reg.fresh; // RULE_09
      assign rst_hit[ch] = match_now[ch]
        & st_reg.match_action_ctrl[ch*ptmc_pkg::ACT_STRIDE + ptmc_pkg::ACT_RST_BIT]; // RULE_06
      assign stop_hit[ch] = match_evt[ch]
        & st_reg.match_action_ctrl[ch*ptmc_pkg::ACT_STRIDE + ptmc_pkg::ACT_STOP_BIT]; // RULE_06
      // Selected edges of the synchronised input
      assign cap_evt[ch] =
        (cap_if.rise[ch]
          & st_reg.snapshot_edge_ctrl[ch*ptmc_pkg::EDGE_STRIDE + ptmc_pkg::EDGE_RISE_BIT])
        | (cap_if.fall[ch]
          & st_reg.snapshot_edge_ctrl[ch*ptmc_pkg::EDGE_STRIDE + ptmc_pkg::EDGE_FALL_BIT]);
    end
  endgenerate

  assign stop_now = |stop_hit;
  assign counting = st_reg.counter_ctrl[ptmc_pkg::CTRL_EN_BIT]
    & ~st_reg.counter_ctrl[ptmc_pkg::CTRL_CLR_BIT];
  assign step = counting & ~stop_now & (st_reg.divider_count == st_reg.divider_limit);

  // ==========================================================
  // Bus decode and read mux
  assign wr = psel & penable & pwrite & st_reg.pready;
  assign wr_tick = wr & (paddr == ptmc_pkg::ADDR_TICK);
  assign wr_divc = wr & (paddr == ptmc_pkg::ADDR_DIVC);
  assign wr_ctrl = wr & (paddr == ptmc_pkg::ADDR_CTRL);
  assign wr_pins = wr & (paddr == ptmc_pkg::ADDR_PINS);
  assign wr_flags = wr & (paddr == ptmc_pkg::ADDR_FLAGS);

  always_comb begin
    mapped = 1'b1;
    rdata = ptmc_pkg::RST_WORD;
    unique case (paddr)
      ptmc_pkg::ADDR_FLAGS: rdata = 32'(st_reg.event_flags); // RULE_15
      ptmc_pkg::ADDR_CTRL: rdata = 32'(st_reg.counter_ctrl);
      ptmc_pkg::ADDR_TICK: rdata = st_reg.tick_count;
      ptmc_pkg::ADDR_LIMIT: rdata = st_reg.divider_limit;
      ptmc_pkg::ADDR_DIVC: rdata = st_reg.divider_count;
      ptmc_pkg::ADDR_ACTION: rdata = 32'(st_reg.match_action_ctrl);
      ptmc_pkg::ADDR_EDGE: rdata = 32'(st_reg.snapshot_edge_ctrl);
      ptmc_pkg::ADDR_PINS: rdata = 32'(st_reg.compare_pin_ctrl); // RULE_16
      default: begin
        mapped = 1'b0;
        for (int i = 0; i < ptmc_pkg::NCH; i++) begin
          if (paddr == ptmc_pkg::ADDR_CMP0 + ptmc_pkg::ADDR_STRIDE * 32'(i)) begin
            mapped = 1'b1;
            rdata = st_reg.compare_value[i];
          end
          if (paddr == ptmc_pkg::ADDR_SNAP0 + ptmc_pkg::ADDR_STRIDE * 32'(i)) begin
            mapped = 1'b1;
            rdata = st_reg.snapshot_value[i];
          end
        end
      end
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    if (pclk_en) begin
      // One wait-free access: answer raised in the setup cycle
      st_next.pready = psel & ~penable;
      st_next.pslverr = psel & ~penable & ~mapped;
      if (psel & ~penable) begin
        st_next.prdata = rdata;
      end
      // Counters
      if (st_reg.counter_ctrl[ptmc_pkg::CTRL_CLR_BIT]) begin
        st_next.tick_count = ptmc_pkg::RST_WORD; // RULE_02
        st_next.divider_count = ptmc_pkg::RST_WORD; // RULE_02
      end else if (counting & ~stop_now) begin // RULE_01
        if (step) begin
          st_next.divider_count = ptmc_pkg::RST_WORD; // RULE_04
          if (|rst_hit) begin
            st_next.tick_count = ptmc_pkg::RST_WORD; // RULE_08
          end else begin
            st_next.tick_count = st_reg.tick_count + ptmc_pkg::ONE_WORD; // RULE_03
          end
        end else begin
          st_next.divider_count = st_reg.divider_count + ptmc_pkg::ONE_WORD; // RULE_04
        end
      end
      // Flag clear by software, before hardware sets so a set wins
      if (wr_flags) begin
        st_next.event_flags = st_reg.event_flags & ~pwdata[7:0]; // RULE_18
      end
      // Match actions
      for (int i = 0; i < ptmc_pkg::NCH; i++) begin
        if (match_evt[i]) begin
          if (st_reg.match_action_ctrl[i*ptmc_pkg::ACT_STRIDE + ptmc_pkg::ACT_IRQ_BIT]) begin
            st_next.event_flags[i] = 1'b1; // RULE_09
          end
          if (stop_hit[i]) begin
            st_next.counter_ctrl[ptmc_pkg::CTRL_EN_BIT] = 1'b0; // RULE_07 RULE_10
          end
          unique case (ptmc_pkg::ptmc_pin_act_e'(
              st_reg.compare_pin_ctrl[ptmc_pkg::PIN_FIELD_LSB + i*ptmc_pkg::PIN_FIELD_W
              +: ptmc_pkg::PIN_FIELD_W]))
            ptmc_pkg::PIN_KEEP: st_next.compare_pin_ctrl[i] = st_reg.compare_pin_ctrl[i];
            ptmc_pkg::PIN_LOW: st_next.compare_pin_ctrl[i] = 1'b0; // RULE_17
            ptmc_pkg::PIN_HIGH: st_next.compare_pin_ctrl[i] = 1'b1; // RULE_17
            ptmc_pkg::PIN_TOGGLE: st_next.compare_pin_ctrl[i] = ~st_reg.compare_pin_ctrl[i];
          endcase
        end
        // Capture loads, on either or both enabled edges
        if (cap_evt[i]) begin
          st_next.snapshot_value[i] = st_reg.tick_count; // RULE_11 RULE_12 RULE_13
          if (st_reg.snapshot_edge_ctrl[i*ptmc_pkg::EDGE_STRIDE + ptmc_pkg::EDGE_IRQ_BIT]) begin
            st_next.event_flags[ptmc_pkg::FLAG_CAP_LSB + i] = 1'b1; // RULE_14 RULE_15
          end
        end
      end
      // Register writes, taking precedence over counting
      if (wr_ctrl) begin
        st_next.counter_ctrl = pwdata[1:0];
      end
      if (wr_tick) begin
        st_next.tick_count = pwdata; // RULE_21
      end
      if (wr_divc) begin
        st_next.divider_count = pwdata; // RULE_21
      end
      if (wr & (paddr == ptmc_pkg::ADDR_LIMIT)) begin
        st_next.divider_limit = pwdata;
      end
      if (wr & (paddr == ptmc_pkg::ADDR_ACTION)) begin
        st_next.match_action_ctrl = pwdata[11:0];
      end
      if (wr & (paddr == ptmc_pkg::ADDR_EDGE)) begin
        st_next.snapshot_edge_ctrl = pwdata[11:0];
      end
      if (wr_pins) begin
        st_next.compare_pin_ctrl = pwdata[11:0];
      end
      for (int i = 0; i < ptmc_pkg::NCH; i++) begin
        if (wr & (paddr == ptmc_pkg::ADDR_CMP0 + ptmc_pkg::ADDR_STRIDE * 32'(i))) begin
          st_next.compare_value[i] = pwdata;
        end
      end
      // A new tick value arms the match events for one cycle
      st_next.fresh = st_next.tick_count != st_reg.tick_count;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.counter_ctrl <= ptmc_pkg::RST_CTRL;
      st_reg.tick_count <= ptmc_pkg::RST_WORD;
      st_reg.divider_limit <= ptmc_pkg::RST_WORD;
      st_reg.divider_count <= ptmc_pkg::RST_WORD;
      st_reg.match_action_ctrl <= ptmc_pkg::RST_CFG12;
      st_reg.compare_value <= '0;
      st_reg.snapshot_edge_ctrl <= ptmc_pkg::RST_CFG12;
      st_reg.snapshot_value <= '0;
      st_reg.compare_pin_ctrl <= ptmc_pkg::RST_CFG12;
      st_reg.event_flags <= ptmc_pkg::RST_FLAGS;
      st_reg.fresh <= 1'b0;
      st_reg.prdata <= ptmc_pkg::RST_WORD;
      st_reg.pready <= 1'b0;
      st_reg.pslverr <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign compare_output = st_reg.compare_pin_ctrl[3:0]; // RULE_16

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_HOLD: assert property ( // RULE_01
    pclk_en && st_reg.counter_ctrl == 2'h0 && !wr_tick && !wr_divc
    |=> $stable(st_reg.tick_count) && $stable(st_reg.divider_count))
    else $error("counters moved while disabled");

  AST_CLEAR: assert property ( // RULE_02
    pclk_en && st_reg.counter_ctrl[ptmc_pkg::CTRL_CLR_BIT] && !wr_tick && !wr_divc
    |=> st_reg.tick_count == 32'h0000_0000 && st_reg.divider_count == 32'h0000_0000)
    else $error("counters not cleared");

  AST_WRAP: assert property ( // RULE_03
    pclk_en && step && st_reg.tick_count == 32'hFFFF_FFFF && !(|rst_hit) && !wr_tick
      && !wr_flags && !(|match_evt)
    |=> st_reg.tick_count == 32'h0000_0000 && $stable(st_reg.event_flags[3:0]))
    else $error("tick counter did not wrap quietly");

  AST_DIVIDE: assert property ( // RULE_04
    pclk_en && counting && !stop_now && !wr_divc
      && st_reg.divider_count != st_reg.divider_limit
    |=> st_reg.divider_count == $past(st_reg.divider_count) + 32'h0000_0001)
    else $error("divider counter did not advance");

  AST_MATCH_CLEAR: assert property ( // RULE_08
    pclk_en && step && (|rst_hit) && !wr_tick
    |=> st_reg.tick_count == 32'h0000_0000)
    else $error("tick counter not cleared on match");

  AST_MATCH_FLAG: assert property ( // RULE_09
    pclk_en && match_evt[1] && st_reg.match_action_ctrl[3]
    |=> st_reg.event_flags[1])
    else $error("match flag not set");

  AST_STOP: assert property ( // RULE_10
    pclk_en && stop_hit[0] && !wr_ctrl && !wr_tick
    |=> !st_reg.counter_ctrl[ptmc_pkg::CTRL_EN_BIT] && $stable(st_reg.tick_count))
    else $error("stop on match failed");

  AST_CAPTURE: assert property ( // RULE_11
    pclk_en && cap_if.rise[0] && st_reg.snapshot_edge_ctrl[0]
    |=> st_reg.snapshot_value[0] == $past(st_reg.tick_count))
    else $error("rising capture missed");

  AST_CAP_FLAG: assert property ( // RULE_14
    pclk_en && cap_evt[3] && st_reg.snapshot_edge_ctrl[11]
    |=> st_reg.event_flags[7])
    else $error("capture flag not set");

  AST_TOGGLE: assert property ( // RULE_17
    pclk_en && match_evt[0] && st_reg.compare_pin_ctrl[5:4] == 2'h3 && !wr_pins
    |=> compare_output[0] != $past(compare_output[0]))
    else $error("compare output did not toggle");

  AST_W1C: assert property ( // RULE_18
    pclk_en && wr_flags && pwdata[4] && !cap_evt[0]
    |=> !st_reg.event_flags[4])
    else $error("flag not cleared by write");

  AST_BUS_WINS: assert property ( // RULE_21
    pclk_en && wr_tick
    |=> st_reg.tick_count == $past(pwdata))
    else $error("bus write to tick counter lost");

endmodule

// ==== bench/ptmc_pins_model.sv ====
// Pin-side partner: drives the twelve capture pins, watches compare outputs.
// Assumes the bench calls its tasks from procedural code on pclk.
`timescale 1ns/1ps
module ptmc_pins_model (
  // Clock
  input wire logic pclk,
  // Pins
  input wire logic [3:0] compare_output,
  output logic [11:0] pins
);
  // ==========================================================
  // Pin levels, all idle low from time zero
  initial begin
    pins = 12'h000;
  end

  // Change one pin level just after a rising edge
  task automatic set_pin(input int idx, input logic lvl);
    @(posedge pclk);
    pins[idx] <= lvl;
  endtask

  // Last seen compare output state
  function automatic logic [3:0] seen();
    return compare_output;
  endfunction
endmodule

// ==== bench/ptmc_top_tb.sv ====
// Self-checking bench for the timer with match and capture channels.
// Assumes zero-wait APB slave answering in the access cycle.
`timescale 1ns/1ps
module ptmc_top_tb;
  // ==========================================================
  // Signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic pclk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [11:0] snapshot_input;
  logic [3:0] compare_output;
  int errors = 0;
  int total_checks = 0;

  // Clock, 25 ns period
  always #12.5 pclk = ~pclk;

  // ==========================================================
  // Instances
  ptmc_top i_dut (
    .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .snapshot_input(snapshot_input), .compare_output(compare_output)
  );
  ptmc_pins_model i_pins (
    .pclk(pclk), .compare_output(compare_output), .pins(snapshot_input)
  );

  // ==========================================================
  // Comparison and bus tasks
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer taken at the rising edge that samples pready high
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0000_0001, 32'h0000_0000);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(exp, q);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rd(ptmc_pkg::ADDR_CTRL, 32'h0000_0000);
    rd(ptmc_pkg::ADDR_TICK, 32'h0000_0000);
    rd(ptmc_pkg::ADDR_ACTION, 32'h0000_0000);
    rd(ptmc_pkg::ADDR_EDGE, 32'h0000_0000);
    rd(ptmc_pkg::ADDR_PINS, 32'h0000_0000);
    apb(1'b0, 32'hE000_4040, 32'h0000_0000, q, e);
    chk(32'h0000_0001, {31'h0, e});
    $display("test reset done");
  endtask

  // Enable spans four counting edges; five more are frozen by pclk_en low
  task automatic t_prescale();
    for (int lim = 0; lim < 2; lim++) begin
      wr(ptmc_pkg::ADDR_LIMIT, lim);
      wr(ptmc_pkg::ADDR_TICK, 32'h0000_0000);
      wr(ptmc_pkg::ADDR_DIVC, 32'h0000_0000);
      wr(ptmc_pkg::ADDR_CTRL, 32'h0000_0001);
      @(posedge pclk);
      pclk_en <= 1'b0;
      repeat (5) @(posedge pclk);
      pclk_en <= 1'b1;
      wr(ptmc_pkg::ADDR_CTRL, 32'h0000_0000);
      rd(ptmc_pkg::ADDR_TICK, (lim == 0) ? 32'h0000_0004 : 32'h0000_0002);
      rd(ptmc_pkg::ADDR_DIVC, 32'h0000_0000);
      rd(ptmc_pkg::ADDR_TICK, (lim == 0) ? 32'h0000_0004 : 32'h0000_0002);
    end
    $display("test prescale done");
  endtask

  task automatic t_stop();
    wr(ptmc_pkg::ADDR_LIMIT, 32'h0000_0002);
    wr(ptmc_pkg::ADDR_CMP0, 32'h0000_0006);
    wr(ptmc_pkg::ADDR_ACTION, 32'h0000_0005);
    wr(ptmc_pkg::ADDR_PINS, 32'h0000_0030);
    wr(ptmc_pkg::ADDR_TICK, 32'h0000_0000);
    wr(ptmc_pkg::ADDR_CTRL, 32'h0000_0001);
    repeat (40) @(posedge pclk);
    rd(ptmc_pkg::ADDR_CTRL, 32'h0000_0000);
    rd(ptmc_pkg::ADDR_TICK, 32'h0000_0006);
    rd(ptmc_pkg::ADDR_FLAGS, 32'h0000_0001);
    rd(ptmc_pkg::ADDR_PINS, 32'h0000_0031);
    chk(32'h0000_0001, {28'h0, i_pins.seen()});
    wr(ptmc_pkg::ADDR_FLAGS, 32'h0000_0000);
    rd(ptmc_pkg::ADDR_FLAGS, 32'h0000_0001);
    wr(ptmc_pkg::ADDR_FLAGS, 32'h0000_0001);
    rd(ptmc_pkg::ADDR_FLAGS, 32'h0000_0000);
    $display("test stop done");
  endtask

  task automatic t_restart();
    logic [31:0] q;
    logic e;
    wr(ptmc_pkg::ADDR_PINS, 32'h0000_0080);
    wr(ptmc_pkg::ADDR_ACTION, 32'h0000_0018);
    wr(ptmc_pkg::ADDR_CMP0 + ptmc_pkg::ADDR_STRIDE, 32'h0000_0003);
    wr(ptmc_pkg::ADDR_LIMIT, 32'h0000_0000);
    wr(ptmc_pkg::ADDR_TICK, 32'h0000_0000);
    wr(ptmc_pkg::ADDR_CTRL, 32'h0000_0001);
    repeat (40) @(posedge pclk);
    wr(ptmc_pkg::ADDR_CTRL, 32'h0000_0000);
    apb(1'b0, ptmc_pkg::ADDR_TICK, 32'h0000_0000, q, e);
    chk(32'h0000_0001, {31'h0, q <= 32'h0000_0003});
    rd(ptmc_pkg::ADDR_FLAGS, 32'h0000_0002);
    chk(32'h0000_0002, {28'h0, compare_output});
    wr(ptmc_pkg::ADDR_TICK, 32'h0000_0005);
    wr(ptmc_pkg::ADDR_DIVC, 32'h0000_0005);
    wr(ptmc_pkg::ADDR_CTRL, 32'h0000_0003);
    repeat (5) @(posedge pclk);
    rd(ptmc_pkg::ADDR_TICK, 32'h0000_0000);
    rd(ptmc_pkg::ADDR_DIVC, 32'h0000_0000);
    wr(ptmc_pkg::ADDR_CTRL, 32'h0000_0000);
    $display("test restart done");
  endtask

  task automatic t_wrap();
    logic [31:0] q;
    logic e;
    wr(ptmc_pkg::ADDR_CMP0 + 32'h0000_000C, 32'h0000_0100);
    wr(ptmc_pkg::ADDR_ACTION, 32'h0000_0200);
    wr(ptmc_pkg::ADDR_PINS, 32'h0000_0000);
    wr(ptmc_pkg::ADDR_FLAGS, 32'h0000_00FF);
    wr(ptmc_pkg::ADDR_TICK, 32'hFFFF_FFFE);
    wr(ptmc_pkg::ADDR_CTRL, 32'h0000_0001);
    repeat (10) @(posedge pclk);
    wr(ptmc_pkg::ADDR_CTRL, 32'h0000_0000);
    apb(1'b0, ptmc_pkg::ADDR_TICK, 32'h0000_0000, q, e);
    chk(32'h0000_0001, {31'h0, q > 32'h0000_0000 && q < 32'h0000_0020});
    rd(ptmc_pkg::ADDR_FLAGS, 32'h0000_0000);
    $display("test wrap done");
  endtask

  // Counter frozen so every snapshot equals the written tick value
  task automatic t_capture();
    wr(ptmc_pkg::ADDR_EDGE, 32'h0000_0E05);
    wr(ptmc_pkg::ADDR_TICK, 32'h0000_1234);
    i_pins.set_pin(1, 1'b1);
    repeat (8) @(posedge pclk);
    rd(ptmc_pkg::ADDR_SNAP0, 32'h0000_1234);
    rd(ptmc_pkg::ADDR_FLAGS, 32'h0000_0010);
    i_pins.set_pin(9, 1'b1);
    repeat (8) @(posedge pclk);
    rd(ptmc_pkg::ADDR_SNAP0 + 32'h0000_000C, 32'h0000_1234);
    rd(ptmc_pkg::ADDR_FLAGS, 32'h0000_0090);
    wr(ptmc_pkg::ADDR_FLAGS, 32'h0000_00FF);
    wr(ptmc_pkg::ADDR_TICK, 32'h0000_0055);
    i_pins.set_pin(9, 1'b0);
    i_pins.set_pin(1, 1'b0);
    repeat (8) @(posedge pclk);
    rd(ptmc_pkg::ADDR_SNAP0 + 32'h0000_000C, 32'h0000_0055);
    rd(ptmc_pkg::ADDR_SNAP0, 32'h0000_1234);
    rd(ptmc_pkg::ADDR_FLAGS, 32'h0000_0080);
    wr(ptmc_pkg::ADDR_EDGE, 32'h0000_0002);
    wr(ptmc_pkg::ADDR_TICK, 32'h0000_0077);
    i_pins.set_pin(0, 1'b1);
    i_pins.set_pin(0, 1'b0);
    repeat (8) @(posedge pclk);
    rd(ptmc_pkg::ADDR_SNAP0, 32'h0000_0077);
    wr(ptmc_pkg::ADDR_SNAP0, 32'h0000_9999);
    rd(ptmc_pkg::ADDR_SNAP0, 32'h0000_0077);
    $display("test capture done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset();
    t_prescale();
    t_stop();
    t_restart();
    t_wrap();
    t_capture();
    final_report();
  end

  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #500us;
    errors++;
    final_report();
  end
endmodule
